// ==== rtl/sef_event_flags.sv ====
`timescale 1ns/1ps
`include "sef_defs.svh"

module sef_event_flags
    import sef_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_read_i,
    output logic      [15:0] reg_rdata_o,
    // masks held in the outer mask bank
    input  wire logic [15:0] mask_status_one_i,
    input  wire logic [15:0] mask_status_two_i,
    input  wire logic [15:0] mask_undervoltage_i,
    input  wire logic [15:0] mask_overcurrent_i,
    input  wire logic [15:0] mask_pin_event_i,
    input  wire logic [15:0] mask_comparator_wake_i,
    input  wire logic [15:0] mask_summary_i,
    input  wire logic [25:0] pin_trigger_i,
    // raw sources
    input  wire logic        charger_fastready_i,
    input  wire logic        clock_periodic_i,
    input  wire logic        clock_second_tick_i,
    input  wire logic        clock_alarm_i,
    input  wire logic [2:0]  battery_below_i,
    input  wire logic        sink_one_unregulated_i,
    input  wire logic        sink_two_unregulated_i,
    input  wire logic        usb_switch_limit_i,
    input  wire logic        supply_shutdown_cmp_i,
    input  wire logic        die_warm_i,
    input  wire logic        die_hot_i,
    input  wire logic        watchdog_expiry_i,
    input  wire logic [3:0]  linear_reg_low_i,
    input  wire logic [5:0]  switcher_low_i,
    input  wire logic        limit_switch_overload_i,
    input  wire logic [12:0] pin_level_i,
    input  wire logic        usb_supply_feedback_i,
    input  wire logic        adaptor_supply_feedback_i,
    input  wire logic        battery_supply_feedback_i,
    input  wire logic [3:0]  codec_detect_i,
    input  wire logic [1:0]  started_from_i,
    input  wire logic        converter_fault_wake_i,
    input  wire logic        heartbeat_missed_wake_i,
    input  wire logic        power_request_pin_held_i,
    input  wire logic        on_key_held_i,
    input  wire logic        wake_pin_held_i,
    output logic [15:0]      summary_o,
    output logic             irq_o
);

    //--------------------------------------------------------------
    // source gathering and synchronisation
    //--------------------------------------------------------------
    logic [`SEF_EDGE_LINES-1:0] raw_lines;
    logic [`SEF_EDGE_LINES-1:0] rise;
    logic [`SEF_EDGE_LINES-1:0] fall;

    // line order: 0..6 status one sources, 7..13 status two,
    // 14..23 under-voltage, 24 over-current, 25..37 pins,
    // 38..44 feedback and codec, 45..51 wake causes
    assign raw_lines = {wake_pin_held_i, on_key_held_i, power_request_pin_held_i,
                        heartbeat_missed_wake_i, converter_fault_wake_i,
                        started_from_i[1], started_from_i[0],
                        codec_detect_i,
                        battery_supply_feedback_i, adaptor_supply_feedback_i,
                        usb_supply_feedback_i,
                        pin_level_i,
                        limit_switch_overload_i,
                        switcher_low_i, linear_reg_low_i,
                        watchdog_expiry_i, die_hot_i, die_warm_i,
                        supply_shutdown_cmp_i, usb_switch_limit_i,
                        sink_two_unregulated_i, sink_one_unregulated_i,
                        battery_below_i,
                        clock_alarm_i, clock_second_tick_i, clock_periodic_i,
                        charger_fastready_i};

    sef_edge_sync #(.WIDTH(`SEF_EDGE_LINES)) u_sync
    (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .raw_i   (raw_lines),
        .rise_o  (rise),
        .fall_o  (fall)
    );

    //--------------------------------------------------------------
    // per-register set vectors
    //--------------------------------------------------------------
    sef_word_type set_one;
    sef_word_type set_two;
    sef_word_type set_uv;
    sef_word_type set_oc;
    sef_word_type set_pin;
    sef_word_type set_cw;
    logic [12:0]  pin_hit;

    genvar g;
    generate
        for (g = 0; g < `SEF_PIN_COUNT; g++)
        begin : g_pin
            sef_trig_type trig;
            assign trig = sef_trig_type'(pin_trigger_i[2*g+1:2*g]);
            assign pin_hit[g] = ((trig == SEF_TRIG_RISE) && rise[25+g])
                             || ((trig == SEF_TRIG_FALL) && fall[25+g])
                             || ((trig == SEF_TRIG_BOTH) && (rise[25+g] || fall[25+g]));
        end
    endgenerate

    always_comb
    begin
        set_one = '0;
        set_two = '0;
        set_uv  = '0;
        set_oc  = '0;
        set_pin = '0;
        set_cw  = '0;
        set_one[`SEF_B1_FASTREADY] = rise[0];
        set_one[`SEF_B1_PERIODIC]  = rise[1];
        set_one[`SEF_B1_SECOND]    = rise[2];
        set_one[`SEF_B1_ALARM]     = rise[3];
        // battery thresholds, index 2 is highest
        set_one[`SEF_B1_BATT_LOW]  = rise[4];
        set_one[`SEF_B1_BATT_MID]  = rise[5];
        set_one[`SEF_B1_BATT_HIGH] = rise[6];
        set_two[`SEF_B2_SINK_ONE]  = rise[7];
        set_two[`SEF_B2_SINK_TWO]  = rise[8];
        set_two[`SEF_B2_USB_LIMIT] = rise[9];
        set_two[`SEF_B2_SHUTDOWN_CMP] = rise[10];
        set_two[`SEF_B2_DIE_WARM]  = rise[11];
        set_two[`SEF_B2_DIE_HOT]   = rise[12];
        set_two[`SEF_B2_WATCHDOG]  = rise[13];
        set_uv[`SEF_UV_LINEAR_LSB +: `SEF_LINEAR_COUNT] = rise[17:14];
        set_uv[`SEF_UV_SWITCH_LSB +: `SEF_SWITCH_COUNT] = rise[23:18];
        set_oc[`SEF_OC_LIMIT_SWITCH] = rise[24];
        set_pin[12:0] = pin_hit;
        set_cw[`SEF_CW_USB_SUPPLY_FEEDBACK]     = rise[38] | fall[38];
        set_cw[`SEF_CW_ADAPTOR_FB] = rise[39] | fall[39];
        set_cw[`SEF_CW_BATTERY_FB] = rise[40] | fall[40];
        set_cw[`SEF_CW_MIC_PRESENT] = rise[41] | fall[41];
        set_cw[`SEF_CW_MIC_SHORT]   = rise[42] | fall[42];
        set_cw[`SEF_CW_RIGHT_JACK]  = rise[43] | fall[43];
        set_cw[`SEF_CW_LEFT_JACK]   = rise[44] | fall[44];
        set_cw[`SEF_CW_FROM_OFF]   = rise[45];
        set_cw[`SEF_CW_FROM_SLEEP] = rise[46];
        set_cw[`SEF_CW_CONV_FAULT] = rise[47];
        set_cw[`SEF_CW_HEARTBEAT]  = rise[48];
        set_cw[`SEF_CW_POWER_PIN]  = rise[49];
        set_cw[`SEF_CW_ON_KEY]     = rise[50];
        set_cw[`SEF_CW_WAKE_PIN]   = rise[51];
    end

    //--------------------------------------------------------------
    // sticky status registers
    //--------------------------------------------------------------
    sef_word_type event_status_one;
    sef_word_type event_status_two;
    sef_word_type undervoltage_status;
    sef_word_type overcurrent_status;
    sef_word_type pin_event_status;
    sef_word_type comparator_wake_status;
    logic         rd_one, rd_two, rd_uv, rd_oc, rd_pin, rd_cw, rd_sum;

    assign rd_one = reg_read_i && (reg_addr_i == `SEF_ADDR_STATUS_ONE);
    assign rd_two = reg_read_i && (reg_addr_i == `SEF_ADDR_STATUS_TWO);
    assign rd_uv  = reg_read_i && (reg_addr_i == `SEF_ADDR_UNDERVOLTAGE);
    assign rd_oc  = reg_read_i && (reg_addr_i == `SEF_ADDR_OVERCURRENT);
    assign rd_pin = reg_read_i && (reg_addr_i == `SEF_ADDR_PIN_EVENT);
    assign rd_cw  = reg_read_i && (reg_addr_i == `SEF_ADDR_COMPARATOR_WAKE);
    assign rd_sum = reg_read_i && (reg_addr_i == `SEF_ADDR_SUMMARY);

    // clear on read; a same-cycle set wins
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            event_status_one       <= `SEF_STATUS_RESET;
            event_status_two       <= `SEF_STATUS_RESET;
            undervoltage_status    <= `SEF_STATUS_RESET;
            overcurrent_status     <= `SEF_STATUS_RESET;
            pin_event_status       <= `SEF_STATUS_RESET;
            comparator_wake_status <= `SEF_STATUS_RESET;
        end
        else
        begin
            event_status_one       <= (rd_one ? 16'h0000 : event_status_one) | set_one;
            event_status_two       <= (rd_two ? 16'h0000 : event_status_two) | set_two;
            undervoltage_status    <= (rd_uv ? 16'h0000 : undervoltage_status) | set_uv;
            overcurrent_status     <= (rd_oc ? 16'h0000 : overcurrent_status) | set_oc;
            pin_event_status       <= (rd_pin ? 16'h0000 : pin_event_status) | set_pin;
            comparator_wake_status <= (rd_cw ? 16'h0000 : comparator_wake_status) | set_cw;
        end
    end

    //--------------------------------------------------------------
    // first-level summary and interrupt
    //--------------------------------------------------------------
    sef_word_type next_summary;
    sef_word_type live_one, live_two, live_uv, live_oc, live_pin, live_cw;

    // mask bit high blocks the flag
    assign live_one = event_status_one       & ~mask_status_one_i;
    assign live_two = event_status_two       & ~mask_status_two_i;
    assign live_uv  = undervoltage_status    & ~mask_undervoltage_i;
    assign live_oc  = overcurrent_status     & ~mask_overcurrent_i;
    assign live_pin = pin_event_status       & ~mask_pin_event_i;
    assign live_cw  = comparator_wake_status & ~mask_comparator_wake_i;

    // group unmasked flags into summary bits
    always_comb
    begin
        next_summary = '0;
        next_summary[`SEF_SUM_CHG]   = |{live_one[15:9], live_one[2:0]};
        next_summary[`SEF_SUM_RTC]   = |live_one[7:5];
        next_summary[`SEF_SUM_CS]    = |live_two[13:12];
        next_summary[`SEF_SUM_USB]   = live_two[10];
        next_summary[`SEF_SUM_SYS]   = |live_two[3:0];
        next_summary[`SEF_SUM_UV]    = |live_uv;
        next_summary[`SEF_SUM_OC]    = |live_oc;
        next_summary[`SEF_SUM_GP]    = |live_pin;
        next_summary[`SEF_SUM_EXT]   = |live_cw[15:13];
        next_summary[`SEF_SUM_CODEC] = |live_cw[11:8];
        next_summary[`SEF_SUM_WKUP]  = |live_cw[6:0];
    end

    // summary is sticky and clears on its own read
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            summary_o <= `SEF_STATUS_RESET;
        else
            summary_o <= (rd_sum ? 16'h0000 : summary_o) | next_summary;
    end

    // summary mask gates the output line
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(next_summary & ~mask_summary_i);
    end

    //--------------------------------------------------------------
    // read data, registered; unmapped addresses read zero
    //--------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            reg_rdata_o <= 16'h0000;
        else if (rd_one)
            reg_rdata_o <= event_status_one;
        else if (rd_two)
            reg_rdata_o <= event_status_two;
        else if (rd_uv)
            reg_rdata_o <= undervoltage_status;
        else if (rd_oc)
            reg_rdata_o <= overcurrent_status;
        else if (rd_pin)
            reg_rdata_o <= pin_event_status;
        else if (rd_cw)
            reg_rdata_o <= comparator_wake_status;
        else if (rd_sum)
            reg_rdata_o <= summary_o;
        else if (reg_read_i)
            reg_rdata_o <= 16'h0000;
    end

endmodule : sef_event_flags

// ==== rtl/sef_defs.svh ====
`ifndef SEF_DEFS_SVH
`define SEF_DEFS_SVH

// register addresses of the status bank
`define SEF_ADDR_SUMMARY         8'h18
`define SEF_ADDR_STATUS_ONE      8'h19
`define SEF_ADDR_STATUS_TWO      8'h1A
`define SEF_ADDR_UNDERVOLTAGE    8'h1C
`define SEF_ADDR_OVERCURRENT     8'h1D
`define SEF_ADDR_PIN_EVENT       8'h1E
`define SEF_ADDR_COMPARATOR_WAKE 8'h1F

// reset value of every status register
`define SEF_STATUS_RESET 16'h0000

// field positions, first event status register
`define SEF_B1_FASTREADY    9
`define SEF_B1_PERIODIC     7
`define SEF_B1_SECOND       6
`define SEF_B1_ALARM        5
`define SEF_B1_BATT_HIGH    2
`define SEF_B1_BATT_MID     1
`define SEF_B1_BATT_LOW     0

// field positions, second event status register
`define SEF_B2_SINK_ONE     13
`define SEF_B2_SINK_TWO     12
`define SEF_B2_USB_LIMIT    10
`define SEF_B2_SHUTDOWN_CMP 3
`define SEF_B2_DIE_WARM     2
`define SEF_B2_DIE_HOT      1
`define SEF_B2_WATCHDOG     0

// under-voltage layout
`define SEF_UV_LINEAR_LSB   8
`define SEF_UV_SWITCH_LSB   0

// over-current layout
`define SEF_OC_LIMIT_SWITCH 15

// comparator and wake layout
`define SEF_CW_USB_SUPPLY_FEEDBACK       15
`define SEF_CW_ADAPTOR_FB   14
`define SEF_CW_BATTERY_FB   13
`define SEF_CW_LEFT_JACK    11
`define SEF_CW_RIGHT_JACK   10
`define SEF_CW_MIC_SHORT    9
`define SEF_CW_MIC_PRESENT  8
`define SEF_CW_FROM_OFF     6
`define SEF_CW_FROM_SLEEP   5
`define SEF_CW_CONV_FAULT   4
`define SEF_CW_HEARTBEAT    3
`define SEF_CW_POWER_PIN    2
`define SEF_CW_ON_KEY       1
`define SEF_CW_WAKE_PIN     0

// first-level summary bit positions
`define SEF_SUM_OC          13
`define SEF_SUM_UV          12
`define SEF_SUM_CS          9
`define SEF_SUM_EXT         8
`define SEF_SUM_CODEC       7
`define SEF_SUM_GP          6
`define SEF_SUM_RTC         4
`define SEF_SUM_SYS         3
`define SEF_SUM_CHG         2
`define SEF_SUM_USB         1
`define SEF_SUM_WKUP        0

// counts
`define SEF_LINEAR_COUNT    4
`define SEF_SWITCH_COUNT    6
`define SEF_PIN_COUNT       13
`define SEF_EDGE_LINES      52

`endif

// ==== rtl/sef_pkg.sv ====
package sef_pkg;

    // trigger selection for a general-purpose pin
    typedef enum logic [1:0]
    {
        SEF_TRIG_RISE = 2'h0,
        SEF_TRIG_FALL = 2'h1,
        SEF_TRIG_BOTH = 2'h3,
        SEF_TRIG_NONE = 2'h2
    } sef_trig_type;

    typedef logic [15:0] sef_word_type;

endpackage : sef_pkg

// ==== rtl/sef_edge_sync.sv ====
`timescale 1ns/1ps
`include "sef_defs.svh"

// three-stage synchroniser with edge detection per line
module sef_edge_sync
    import sef_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] raw_i,
    output logic      [WIDTH-1:0] rise_o,
    output logic      [WIDTH-1:0] fall_o
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] mid;
    logic [WIDTH-1:0] late;
    logic [WIDTH-1:0] level;

    // first stage is read only by the second
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta <= '0;
            mid  <= '0;
            late <= '0;
        end
        else
        begin
            meta <= raw_i;
            mid  <= meta;
            late <= mid;
        end
    end

    // a change counts once stage two and three agree
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            level <= '0;
        else
            level <= (mid == late) ? mid : level;
    end

    always_comb
    begin
        rise_o = ((mid & late) | level) & ~level & (mid & late);
        fall_o = level & ~(mid | late);
    end

endmodule : sef_edge_sync

// ==== bench/sef_event_flags_monitor.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// port watcher for the status bank
// ----------------------------------------
module sef_event_flags_check
(
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_read_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic [15:0] mask_summary_i,
    input wire logic [15:0] summary_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_reset_reads_zero: assert property ($rose(rst_b_i) |-> !reg_rdata_o && !summary_o)
        else $error("outputs not zero after reset");
    a_rdata_holds: assert property (!$past(reg_read_i) |-> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (reg_read_i && !(reg_addr_i inside {8'h18, 8'h19,
        8'h1A, 8'h1C, 8'h1D, 8'h1E, 8'h1F}) |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_summary_sticky: assert property ((($past(summary_o) & ~summary_o) != 16'h0000) |->
        $past(reg_read_i) && $past(reg_addr_i) == 8'h18)
        else $error("summary bit dropped without a read");
    a_irq_masked: assert property ((mask_summary_i == 16'hFFFF) [*2] |=> !irq_o)
        else $error("irq high while fully masked");
    a_oc_reserved: assert property (reg_read_i && reg_addr_i == 8'h1D |=> !reg_rdata_o[14:0])
        else $error("over-current spare bits set");
    a_uv_reserved: assert property (reg_read_i && reg_addr_i == 8'h1C |=>
        !reg_rdata_o[15:12] && !reg_rdata_o[7:6])
        else $error("under-voltage spare bits set");
    a_cw_reserved: assert property (reg_read_i && reg_addr_i == 8'h1F |=>
        !reg_rdata_o[12] && !reg_rdata_o[7])
        else $error("comparator spare bits set");
endmodule : sef_event_flags_check

bind sef_event_flags sef_event_flags_check u_check
(
    .clk_i          (clk_i),
    .rst_b_i        (rst_b_i),
    .reg_addr_i     (reg_addr_i),
    .reg_read_i     (reg_read_i),
    .reg_rdata_o    (reg_rdata_o),
    .mask_summary_i (mask_summary_i),
    .summary_o      (summary_o),
    .irq_o          (irq_o)
);

// ==== bench/sef_host_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// host reading over the register port
// ----------------------------------------
module sef_host_model
(
    input  wire logic [15:0] reg_rdata_i,
    input  wire logic        clk_i,
    output logic      [7:0]  reg_addr_o,
    output logic             reg_read_o
);
    // idle bus at time zero
    initial
    begin
        reg_addr_o = 8'h00;
        reg_read_o = 1'b0;
    end

    // one strobe, data after the taking edge
    task automatic read(input logic [7:0] addr, output logic [15:0] data);
        @(posedge clk_i);
        #1;
        reg_addr_o = addr;
        reg_read_o = 1'b1;
        @(posedge clk_i);
        #1;
        reg_read_o = 1'b0;
        reg_addr_o = ~addr; // driven to the inverted address, so no stale address
        data = reg_rdata_i;
    endtask : read

    // strobe held high, one word per cycle
    task automatic burst(input logic [7:0] addr, input int n, output int hits);
        hits = 0;
        @(posedge clk_i);
        #1;
        reg_addr_o = addr;
        reg_read_o = 1'b1;
        repeat (n)
        begin
            @(posedge clk_i);
            #1;
            hits += (reg_rdata_i[0] !== 1'b0);
        end
        reg_read_o = 1'b0;
        reg_addr_o = ~addr;
    endtask : burst
endmodule : sef_host_model

// ==== bench/sef_event_flags_bench.sv ====
`timescale 1ns/1ps
`include "sef_defs.svh"

module sef_event_flags_bench
    import sef_pkg::*;
;
    logic        clk_i;
    logic        rst_b_i;
    logic [7:0]  reg_addr_i;
    logic        reg_read_i;
    logic [15:0] reg_rdata_o;
    logic [15:0] summary_o;
    logic        irq_o;
    logic [15:0] mask [7];
    logic [25:0] pin_trigger_i;
    logic [51:0] src;
    logic [15:0] rd;
    logic [7:0]  addr;
    logic [3:0]  bpos;
    int          num_errors;
    int          cmp_count;
    int          hits;

    sef_event_flags u_dut
    (
        .clk_i,
        .rst_b_i,
        .reg_addr_i,
        .reg_read_i,
        .reg_rdata_o,
        .mask_status_one_i(mask[0]),
        .mask_status_two_i(mask[1]),
        .mask_undervoltage_i(mask[2]),
        .mask_overcurrent_i(mask[3]),
        .mask_pin_event_i(mask[4]),
        .mask_comparator_wake_i(mask[5]),
        .mask_summary_i(mask[6]),
        .pin_trigger_i,
        .charger_fastready_i(src[0]),
        .clock_periodic_i(src[1]),
        .clock_second_tick_i(src[2]),
        .clock_alarm_i(src[3]),
        .battery_below_i({src[4], src[5], src[6]}),
        .sink_one_unregulated_i(src[7]),
        .sink_two_unregulated_i(src[8]),
        .usb_switch_limit_i(src[9]),
        .supply_shutdown_cmp_i(src[10]),
        .die_warm_i(src[11]),
        .die_hot_i(src[12]),
        .watchdog_expiry_i(src[13]),
        .linear_reg_low_i(src[17:14]),
        .switcher_low_i(src[23:18]),
        .limit_switch_overload_i(src[24]),
        .pin_level_i(src[37:25]),
        .usb_supply_feedback_i(src[38]),
        .adaptor_supply_feedback_i(src[39]),
        .battery_supply_feedback_i(src[40]),
        .codec_detect_i({src[41], src[42], src[43], src[44]}),
        .started_from_i({src[46], src[45]}),
        .converter_fault_wake_i(src[47]),
        .heartbeat_missed_wake_i(src[48]),
        .power_request_pin_held_i(src[49]),
        .on_key_held_i(src[50]),
        .wake_pin_held_i(src[51]),
        .summary_o,
        .irq_o
    );

    sef_host_model u_host
    (
        .reg_rdata_i(reg_rdata_o),
        .clk_i,
        .reg_addr_o(reg_addr_i),
        .reg_read_o(reg_read_i)
    );

    // free-running clock
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic tally_and_finish();
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
        end
    endtask : check

    // waits long enough for the synchroniser and edge stage
    task automatic set_src(input int i, input logic v);
        @(posedge clk_i);
        #1;
        src[i] = v;
        repeat (8) @(posedge clk_i);
        #1;
    endtask : set_src

    // source index to register address and bit
    function automatic logic [11:0] place(input int i);
        if (i < 1) return {8'h19, 4'(9)};
        if (i < 4) return {8'h19, 4'(8 - i)};
        if (i < 7) return {8'h19, 4'(6 - i)};
        if (i < 9) return {8'h1A, 4'(20 - i)};
        if (i < 10) return {8'h1A, 4'(10)};
        if (i < 14) return {8'h1A, 4'(13 - i)};
        if (i < 18) return {8'h1C, 4'(i - 6)};
        if (i < 24) return {8'h1C, 4'(i - 18)};
        if (i < 25) return {8'h1D, 4'(15)};
        if (i < 38) return {8'h1E, 4'(i - 25)};
        if (i < 41) return {8'h1F, 4'(53 - i)};
        if (i < 45) return {8'h1F, 4'(52 - i)};
        return {8'h1F, 4'(51 - i)};
    endfunction : place

    // a hang would never reach the verdict; ~10000 cycles is ample
    initial
    begin
        #400000;
        num_errors++;
        tally_and_finish();
    end

    // main sequence
    initial
    begin
        num_errors = 0;
        cmp_count = 0;
        rst_b_i = 1'b0;
        src = '0;
        pin_trigger_i = '0;
        foreach (mask[k]) mask[k] = 16'h0000;
        repeat (16) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        for (int a = 8'h18; a <= 8'h1F; a++)
        begin
            u_host.read(8'(a), rd);
            check(rd, 16'h0000);
        end
        // every source alone, rise then fall
        for (int i = 0; i < 52; i++)
        begin
            {addr, bpos} = place(i);
            set_src(i, 1'b1);
            u_host.read(addr, rd);
            check(rd, 16'h0001 << bpos);
            u_host.read(addr, rd);
            check(rd, 16'h0000);
            set_src(i, 1'b0);
            u_host.read(addr, rd);
            check(rd, (i > 37 && i < 45) ? 16'h0001 << bpos : 16'h0000);
        end
        // trigger codes 0 rise, 1 fall, 2 none, 3 both
        for (int m = 0; m < 4; m++)
        begin
            pin_trigger_i[1:0] = 2'(m);
            set_src(25, 1'b1);
            u_host.read(8'h1E, rd);
            check(rd, {15'h0000, m == 0 || m == 3});
            set_src(25, 1'b0);
            u_host.read(8'h1E, rd);
            check(rd, {15'h0000, m == 1 || m == 3});
        end
        // an edge landing among back-to-back reads is seen once
        src[13] = 1'b1;
        u_host.burst(8'h1A, 12, hits);
        check(16'(hits), 16'h0001);
        u_host.read(8'h18, rd);
        set_src(12, 1'b0);
        check({summary_o[15:1], irq_o}, 16'h0000);
        set_src(12, 1'b1);
        check({summary_o[15:1], irq_o}, 16'h0009);
        mask[6] = 16'hFFFF;
        set_src(12, 1'b1);
        check({15'h0000, irq_o}, 16'h0000);
        mask[6] = 16'h0000;
        u_host.read(8'h1A, rd);
        check(rd, 16'h0002);
        u_host.read(8'h18, rd);
        check(rd, 16'h0001 << `SEF_SUM_SYS);
        mask[1] = 16'h0004;
        set_src(11, 1'b1);
        check({summary_o[15:1], irq_o}, 16'h0000);
        u_host.read(8'h1A, rd);
        check(rd, 16'h0004);
        tally_and_finish();
    end
endmodule : sef_event_flags_bench
